// >>> design/fanout_device.sv
// Operation
// R1: Strap caught once after power-up fixes mode
// R2: Pin mode source pick chooses reference
// R3: Pin mode kind pins set output signalling
// R4: Disable code floats outputs at reference fall
// R5: Leaving disable drives low, then tracks
// R6: Serial mode acts as serial slave
// R7: Half duplex, data in ignored on reads
// R8: Clock level at select fall sets order
// R9: Frame is flag, address, then data bytes
// R10: Master holds select low whole access
// R11: Burst continues, address steps per byte
// R12: Source and enable pins become serial pins
// R13: Read flag level parameter, output released idle
// R14: Read bits leave on falling clock edge
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module fanout_device #(
   parameter int   DEPTH    = fanout_pkg::REG_DEPTH,
   parameter logic RD_LEVEL = fanout_pkg::READ_LEVEL
) (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        CE,
   fanout_link_if.dev       LINK,
   input  wire logic        REF_A,
   input  wire logic        REF_B,
   input  wire logic        CRYSTAL,
   output logic             OUT_TRUE,
   output logic             OUT_COMP,
   output logic             OUT_OE,
   output logic [1:0]       OUT_KIND,
   output logic             SE_OUT_ENABLE,
   output logic             SERIAL_MODE,
   output logic             MODE_READY
);
   import fanout_pkg::*;

   localparam int IW = $clog2(DEPTH);

   logic [SYNC_LANES-1:0] raw;
   logic [SYNC_LANES-1:0] meta;
   logic [SYNC_LANES-1:0] sync;
   logic [1:0]            settle;
   logic                  taken;
   logic                  serial;
   logic                  cs_q;
   logic                  sck_q;
   logic                  ref_q;
   logic                  ref_sel;
   logic [1:0]            src_code;
   logic [1:0]            kind;
   out_state_t            ostate;
   logic                  lsb_first;
   logic                  is_read;
   logic                  in_data;
   logic [2:0]            cnt;
   logic [6:0]            addr;
   logic [7:0]            rx;
   logic [7:0]            next_rx;
   logic [7:0]            tx;
   logic                  tx_valid;
   logic                  sdo_bit;
   logic [2:0]            bitpos;
   logic [7:0]            rd_byte;
   logic [7:0]            store [DEPTH];
   logic                  active;
   logic                  cs_fall;
   logic                  sck_rise;
   logic                  sck_fall;
   logic                  ref_fall;
   logic                  wr_fire;

   // ****************************************
   // Input synchronisers
   // ****************************************
   assign raw = {LINK.mode_strap, LINK.single_ended_out_enable, LINK.source_pick_hi, // R12
                 LINK.source_pick_lo, LINK.drive_kind_hi, LINK.drive_kind_lo,
                 CRYSTAL, REF_B, REF_A};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_LANES; gi++) begin : g_sync
         always_ff @(posedge CLK) begin
            if (!RST_B) begin
               meta[gi] <= SYNC_INIT[gi];
               sync[gi] <= SYNC_INIT[gi];
            end else if (CE) begin
               meta[gi] <= raw[gi];
               sync[gi] <= meta[gi];
            end
         end
      end
   endgenerate

   // ****************************************
   // Mode strap
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         settle <= 2'd0;
         taken  <= 1'b0;
         serial <= 1'b0;
      end else if (CE && !taken) begin
         if (settle == 2'(STRAP_SETTLE - 1)) begin
            taken  <= 1'b1; // R1
            serial <= sync[LANE_STRAP]; // R1
         end else begin
            settle <= settle + 2'd1;
         end
      end
   end

   assign SERIAL_MODE = serial;
   assign MODE_READY  = taken;

   // ****************************************
   // Edge detection
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cs_q  <= 1'b1;
         sck_q <= 1'b0;
         ref_q <= 1'b0;
      end else if (CE) begin
         cs_q  <= sync[LANE_CS];
         sck_q <= sync[LANE_SCK];
         ref_q <= ref_sel;
      end
   end

   assign active   = taken && serial && !sync[LANE_CS]; // R6
   assign cs_fall  = taken && serial && cs_q && !sync[LANE_CS];
   assign sck_rise = !sck_q && sync[LANE_SCK];
   assign sck_fall = sck_q && !sync[LANE_SCK];
   assign ref_fall = ref_q && !ref_sel;

   // ****************************************
   // Source and output kind
   // ****************************************
   always_comb begin
      if (serial) begin
         src_code = store[REG_SOURCE_IDX[IW-1:0]][1:0];
         kind     = store[REG_KIND_IDX[IW-1:0]][KIND_FIELD_LSB +: 2];
      end else begin
         src_code = {sync[LANE_SDI], sync[LANE_SCK]}; // R2
         kind     = {sync[LANE_KHI], sync[LANE_KLO]}; // R3
      end
      if (src_code[SRC_XTAL_BIT]) begin
         ref_sel = sync[LANE_XTAL]; // R2
      end else if (src_code[SRC_B_BIT]) begin
         ref_sel = sync[LANE_REF_B]; // R2
      end else begin
         ref_sel = sync[LANE_REF_A]; // R2
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ostate <= OUT_OFF;
      end else if (CE && taken) begin
         case (ostate)
            OUT_OFF: begin
               if (kind != KIND_OFF) begin
                  ostate <= OUT_LOW; // R5
               end
            end
            OUT_LOW: begin
               if (ref_fall) begin
                  ostate <= (kind == KIND_OFF) ? OUT_OFF : OUT_TRACK; // R4 R5
               end
            end
            OUT_TRACK: begin
               if (ref_fall && kind == KIND_OFF) begin
                  ostate <= OUT_OFF; // R4
               end
            end
            default: ostate <= OUT_OFF;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         OUT_TRUE      <= 1'b0;
         OUT_COMP      <= 1'b1;
         OUT_OE        <= 1'b0;
         OUT_KIND      <= KIND_LVPECL;
         SE_OUT_ENABLE <= 1'b0;
      end else if (CE) begin
         OUT_TRUE      <= (ostate == OUT_TRACK) && ref_sel; // R5
         OUT_COMP      <= !((ostate == OUT_TRACK) && ref_sel); // R5
         OUT_OE        <= (ostate != OUT_OFF); // R4
         OUT_KIND      <= kind; // R3
         SE_OUT_ENABLE <= taken && (serial || sync[LANE_CS]); // R12
      end
   end

   // ****************************************
   // Serial slave
   // ****************************************
   always_comb begin
      bitpos          = lsb_first ? cnt : 3'd7 - cnt; // R9
      next_rx         = rx;
      next_rx[bitpos] = sync[LANE_SDI];
      wr_fire         = active && sck_rise && in_data && !is_read && cnt == 3'd7; // R7
      rd_byte         = (32'(addr) < DEPTH) ? store[addr[IW-1:0]] : 8'h00;
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         lsb_first <= 1'b0;
         is_read   <= 1'b0;
         in_data   <= 1'b0;
         cnt       <= 3'd0;
         addr      <= 7'h00;
         rx        <= 8'h00;
      end else if (CE) begin
         if (cs_fall) begin
            lsb_first <= sync[LANE_SCK]; // R8
            in_data   <= 1'b0;
            cnt       <= 3'd0;
         end else if (active && sck_rise) begin
            cnt <= cnt + 3'd1;
            if (!in_data) begin
               if (cnt == 3'd0) begin
                  is_read <= (sync[LANE_SDI] == RD_LEVEL); // R9 R13
               end else begin
                  addr[lsb_first ? cnt - 3'd1 : 3'd7 - cnt] <= sync[LANE_SDI]; // R9
               end
               if (cnt == 3'd7) begin
                  in_data <= 1'b1;
               end
            end else begin
               if (!is_read) begin
                  rx <= next_rx; // R7
               end
               if (cnt == 3'd7) begin
                  addr <= addr + 7'd1; // R11
               end
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         tx       <= 8'h00;
         tx_valid <= 1'b0;
         sdo_bit  <= 1'b0;
      end else if (CE) begin
         if (!active) begin
            tx_valid <= 1'b0;
         end else if (sck_fall && in_data && is_read) begin
            if (cnt == 3'd0) begin
               tx       <= rd_byte; // R11
               tx_valid <= 1'b1;
               sdo_bit  <= lsb_first ? rd_byte[0] : rd_byte[7]; // R14
            end else begin
               tx      <= lsb_first ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
               sdo_bit <= lsb_first ? tx[1] : tx[6]; // R14
            end
         end
      end
   end

   assign LINK.sdo    = sdo_bit;
   assign LINK.sdo_oe = active && in_data && is_read && tx_valid; // R13

   // ****************************************
   // Register storage
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         for (int i = 0; i < DEPTH; i++) begin
            store[i] <= STORE_RESET;
         end
      end else if (CE && wr_fire && 32'(addr) < DEPTH) begin
         store[addr[IW-1:0]] <= next_rx; // R9
      end
   end
endmodule : fanout_device

// >>> design/fanout_pkg.sv
package fanout_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS   = 20;
   localparam int SCK_PERIOD_NS   = 160;
   localparam int SCK_HALF_CYCLES = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRAP_SETTLE    = 3;

   // ****************************************
   // Link framing and device storage
   // ****************************************
   localparam int         REG_DEPTH      = 32;
   localparam logic       READ_LEVEL     = 1'b1;
   localparam int         CMD_BITS       = 8;
   localparam int         BYTE_BITS      = 8;
   localparam logic [6:0] REG_SOURCE_IDX = 7'h05;
   localparam logic [6:0] REG_KIND_IDX   = 7'h07;
   localparam int         KIND_FIELD_LSB = 4;
   localparam logic [7:0] STORE_RESET    = 8'h00;

   // ****************************************
   // Source and output kind codes
   // ****************************************
   localparam int         SRC_XTAL_BIT = 1;
   localparam int         SRC_B_BIT    = 0;
   localparam logic [1:0] KIND_LVPECL  = 2'b00;
   localparam logic [1:0] KIND_LVDS    = 2'b01;
   localparam logic [1:0] KIND_HCSL    = 2'b10;
   localparam logic [1:0] KIND_OFF     = 2'b11;

   // ****************************************
   // Device synchroniser lanes
   // ****************************************
   localparam int         SYNC_LANES = 9;
   localparam int         LANE_REF_A = 0;
   localparam int         LANE_REF_B = 1;
   localparam int         LANE_XTAL  = 2;
   localparam int         LANE_KLO   = 3;
   localparam int         LANE_KHI   = 4;
   localparam int         LANE_SCK   = 5;
   localparam int         LANE_SDI   = 6;
   localparam int         LANE_CS    = 7;
   localparam int         LANE_STRAP = 8;
   localparam logic [8:0] SYNC_INIT  = 9'h080;

   // ****************************************
   // Host register map
   // ****************************************
   localparam logic [7:0]  HOST_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  HOST_WDATA_OFS  = 8'h04;
   localparam logic [7:0]  HOST_RDATA_OFS  = 8'h08;
   localparam logic [7:0]  HOST_STATUS_OFS = 8'h0c;
   localparam logic [7:0]  HOST_PINS_OFS   = 8'h10;
   localparam int          CTRL_START_BIT  = 0;
   localparam int          CTRL_READ_BIT   = 1;
   localparam int          CTRL_LSB_BIT    = 2;
   localparam int          CTRL_COUNT_LSB  = 4;
   localparam int          CTRL_ADDR_LSB   = 8;
   localparam int          STAT_BUSY_BIT   = 0;
   localparam int          STAT_DONE_BIT   = 1;
   localparam int          PINS_STRAP_BIT  = 0;
   localparam int          PINS_SRC_LSB    = 1;
   localparam int          PINS_KIND_LSB   = 3;
   localparam int          PINS_SE_OE_BIT  = 5;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] WDATA_RESET     = 32'h0000_0000;
   localparam logic [5:0]  PINS_RESET      = 6'h00;

   typedef enum logic [1:0] {OUT_OFF, OUT_LOW, OUT_TRACK} out_state_t;
   typedef enum logic [2:0] {H_IDLE, H_PARK, H_SELECT, H_LOW, H_HIGH, H_FINISH} host_state_t;
endpackage : fanout_pkg

// >>> design/fanout_link_if.sv
`timescale 1ns/1ns
interface fanout_link_if;
   logic mode_strap;
   logic source_pick_lo;
   logic source_pick_hi;
   logic single_ended_out_enable;
   logic drive_kind_lo;
   logic drive_kind_hi;
   logic sdo;
   logic sdo_oe;
   logic sdo_line;

   // Released line is pulled up
   assign sdo_line = sdo_oe ? sdo : 1'b1;

   modport dev (
      input  mode_strap,
      input  source_pick_lo,
      input  source_pick_hi,
      input  single_ended_out_enable,
      input  drive_kind_lo,
      input  drive_kind_hi,
      output sdo,
      output sdo_oe
   );

   modport host (
      output mode_strap,
      output source_pick_lo,
      output source_pick_hi,
      output single_ended_out_enable,
      output drive_kind_lo,
      output drive_kind_hi,
      input  sdo_line
   );
endinterface : fanout_link_if

// >>> design/fanout_host.sv
`timescale 1ns/1ns
module fanout_host #(
   parameter int   HALF     = fanout_pkg::SCK_HALF_CYCLES,
   parameter logic RD_LEVEL = fanout_pkg::READ_LEVEL
) (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        CE,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   fanout_link_if.host      LINK
);
   import fanout_pkg::*;

   logic        take;
   logic        wr_pend;
   logic [7:0]  wr_ofs;
   logic [31:0] rd_mux;
   logic [31:0] ctrl;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [5:0]  pins;
   logic        done;
   logic        start;
   host_state_t state;
   logic [7:0]  timer;
   logic        tick;
   logic [5:0]  k;
   logic [5:0]  last_k;
   logic [5:0]  d;
   logic        cs;
   logic        sck;
   logic        sdi;
   logic        sdo_meta;
   logic        sdo_s;
   logic        lsb;

   // ****************************************
   // Bus slave
   // ****************************************
   assign take      = HSEL && HTRANS[1] && HREADY && CE;
   assign HREADYOUT = CE;
   assign HRESP     = 1'b0;

   always_comb begin
      case (HADDR[7:0])
         HOST_CTRL_OFS:   rd_mux = ctrl;
         HOST_WDATA_OFS:  rd_mux = wdata;
         HOST_RDATA_OFS:  rd_mux = rdata;
         HOST_STATUS_OFS: rd_mux = {30'h0, done, state != H_IDLE};
         HOST_PINS_OFS:   rd_mux = {26'h0, pins};
         default:         rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         wr_pend <= 1'b0;
         wr_ofs  <= 8'h00;
         HRDATA  <= 32'h0;
      end else if (CE) begin
         wr_pend <= take && HWRITE;
         if (take) begin
            wr_ofs <= HADDR[7:0];
         end
         if (take && !HWRITE) begin
            HRDATA <= rd_mux;
         end
      end
   end

   assign start = wr_pend && wr_ofs == HOST_CTRL_OFS && HWDATA[CTRL_START_BIT]
                  && state == H_IDLE;

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ctrl  <= CTRL_RESET;
         wdata <= WDATA_RESET;
         pins  <= PINS_RESET;
      end else if (CE && wr_pend) begin
         if (wr_ofs == HOST_CTRL_OFS && state == H_IDLE) begin
            ctrl <= {HWDATA[31:1], 1'b0};
         end
         if (wr_ofs == HOST_WDATA_OFS && state == H_IDLE) begin
            wdata <= HWDATA;
         end
         if (wr_ofs == HOST_PINS_OFS) begin
            pins <= HWDATA[5:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         done <= 1'b0;
      end else if (CE) begin
         if (state == H_FINISH && tick) begin
            done <= 1'b1;
         end else if (start) begin
            done <= 1'b0;
         end
      end
   end

   // ****************************************
   // Frame bit source
   // ****************************************
   assign lsb    = ctrl[CTRL_LSB_BIT];
   assign last_k = {1'b0, ctrl[CTRL_COUNT_LSB +: 2], 3'b111} + 6'd8; // R11
   assign d      = k - 6'd8;

   function automatic logic bit_at(input logic [5:0] n);
      logic [5:0] e;
      logic [7:0] by;
      logic [6:0] a;
      e  = n - 6'd8;
      by = wdata[{e[4:3], 3'b000} +: 8];
      a  = ctrl[CTRL_ADDR_LSB +: 7];
      if (n == 6'd0) begin
         bit_at = ctrl[CTRL_READ_BIT] ? RD_LEVEL : !RD_LEVEL; // R9
      end else if (n < 6'(CMD_BITS)) begin
         bit_at = lsb ? a[n[2:0] - 3'd1] : a[3'd7 - n[2:0]]; // R9
      end else begin
         bit_at = lsb ? by[e[2:0]] : by[3'd7 - e[2:0]]; // R9
      end
   endfunction : bit_at

   // ****************************************
   // Serial engine
   // ****************************************
   assign tick = (timer == 8'(HALF - 1));

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         timer <= 8'h00;
      end else if (CE) begin
         timer <= (state == H_IDLE || tick) ? 8'h00 : timer + 8'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         sdo_meta <= 1'b1;
         sdo_s    <= 1'b1;
      end else if (CE) begin
         sdo_meta <= LINK.sdo_line;
         sdo_s    <= sdo_meta;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state <= H_IDLE;
         k     <= 6'd0;
         cs    <= 1'b1;
         sck   <= 1'b0;
         sdi   <= 1'b0;
         rdata <= 32'h0;
      end else if (CE) begin
         case (state)
            H_IDLE: begin
               if (start) begin
                  sck   <= HWDATA[CTRL_LSB_BIT]; // R8
                  k     <= 6'd0;
                  rdata <= 32'h0;
                  state <= H_PARK;
               end
            end
            H_PARK: begin
               if (tick) begin
                  cs    <= 1'b0; // R10
                  state <= H_SELECT;
               end
            end
            H_SELECT: begin
               if (tick) begin
                  sck   <= 1'b0;
                  sdi   <= bit_at(k);
                  state <= H_LOW;
               end
            end
            H_LOW: begin
               if (tick) begin
                  sck   <= 1'b1;
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tick) begin
                  sck <= 1'b0;
                  if (ctrl[CTRL_READ_BIT] && k >= 6'(CMD_BITS)) begin
                     rdata[{d[4:3], lsb ? d[2:0] : 3'd7 - d[2:0]}] <= sdo_s; // R7 R14
                  end
                  if (k == last_k) begin
                     state <= H_FINISH; // R10
                  end else begin
                     k     <= k + 6'd1;
                     sdi   <= bit_at(k + 6'd1);
                     state <= H_LOW;
                  end
               end
            end
            H_FINISH: begin
               if (tick) begin
                  cs    <= 1'b1;
                  state <= H_IDLE;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   // ****************************************
   // Pin sharing
   // ****************************************
   assign LINK.mode_strap              = pins[PINS_STRAP_BIT];
   assign LINK.source_pick_lo          = pins[PINS_STRAP_BIT] ? sck : pins[PINS_SRC_LSB];
   assign LINK.source_pick_hi          = pins[PINS_STRAP_BIT] ? sdi : pins[PINS_SRC_LSB + 1];
   assign LINK.single_ended_out_enable = pins[PINS_STRAP_BIT] ? cs : pins[PINS_SE_OE_BIT];
   assign LINK.drive_kind_lo           = pins[PINS_KIND_LSB];
   assign LINK.drive_kind_hi           = pins[PINS_KIND_LSB + 1];
endmodule : fanout_host

// >>> sim/fanout_props.sv
`timescale 1ns/1ns
module fanout_props #(
   parameter int HALF = fanout_pkg::SCK_HALF_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic mode_strap,
   input wire logic source_pick_lo,
   input wire logic source_pick_hi,
   input wire logic single_ended_out_enable,
   input wire logic sdo,
   input wire logic sdo_oe
);
   // ********
   // Link
   // ********
   wire         cs  = single_ended_out_enable;
   wire         sck = source_pick_lo;
   wire         sdi = source_pick_hi;
   int unsigned low_cnt;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Length of the current select-low stretch
   always_ff @(posedge CLK) begin
      if (!RST_B || cs) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= low_cnt + 1;
      end
   end
   a_oe_idle: assert property (cs [*8] |-> !sdo_oe)
      else $error("sdo driven while idle");
   a_sdo_hold: assert property (sdo_oe && $past(sdo_oe) && sck && $past(sck) &&
      $past(sck, 2) |-> $stable(sdo)) else $error("sdo moved in high half");
   a_select_park: assert property ($fell(cs) && mode_strap |-> $stable(sck) [*4])
      else $error("clock moved at select");
   a_sck_high: assert property ($rose(sck) && !cs && mode_strap |=> sck [*3])
      else $error("short clock high");
   a_sck_low: assert property ($fell(sck) && !cs && mode_strap |=> !sck [*3])
      else $error("short clock low");
   a_sdi_steady: assert property (!cs && !$past(cs) && sck && $past(sck) |->
      $stable(sdi)) else $error("data in moved in high half");
   a_frame_len: assert property ($rose(cs) && mode_strap |-> low_cnt >= 32 * HALF)
      else $error("frame too short");
   a_strap_hold: assert property (!cs && mode_strap |=> mode_strap)
      else $error("strap dropped in frame");
   c_lsb: cover property ($fell(cs) && sck && mode_strap);
   c_msb: cover property ($fell(cs) && !sck && mode_strap);
   c_read: cover property ($rose(sdo_oe));
endmodule : fanout_props

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import fanout_pkg::*;
   // ********
   // Setup
   // ********
   logic        clk = 0, rst_h = 0, rst_d = 0, ref_a = 0, ref_b = 0, xtal = 0, vld = 0;
   logic        hwrite = 0, hready, otrue, ocomp, ooe, smode, mready, seoe, hresp, p = 0;
   logic [1:0]  htrans = 0, okind;
   logic [6:0]  a;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, seen = 0, r, d, rs = 32'h2190040c;
   int          errors = 0, check_count = 0, n, e;
   string       nq[$];
   logic [31:0] eq[$];
   fanout_link_if i_fanout_link_if ();
   fanout_host i_fanout_host (.CLK(clk), .RST_B(rst_h), .CE(1'b1), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .LINK(i_fanout_link_if.host));
   fanout_device i_fanout_device (.CLK(clk), .RST_B(rst_d), .CE(1'b1),
      .LINK(i_fanout_link_if.dev), .REF_A(ref_a), .REF_B(ref_b), .CRYSTAL(xtal),
      .OUT_TRUE(otrue), .OUT_COMP(ocomp), .OUT_OE(ooe), .OUT_KIND(okind), .SE_OUT_ENABLE(seoe),
      .SERIAL_MODE(smode), .MODE_READY(mready));
   fanout_props #(.HALF(SCK_HALF_CYCLES)) i_fanout_props (.CLK(clk), .RST_B(rst_h),
      .mode_strap(i_fanout_link_if.mode_strap), .sdo(i_fanout_link_if.sdo),
      .source_pick_lo(i_fanout_link_if.source_pick_lo),
      .source_pick_hi(i_fanout_link_if.source_pick_hi),
      .single_ended_out_enable(i_fanout_link_if.single_ended_out_enable),
      .sdo_oe(i_fanout_link_if.sdo_oe));
   initial begin
      forever #10 clk = ~clk;
   end
   always #100 ref_a = ~ref_a;
   always #220 ref_b = ~ref_b;
   always #380 xtal = ~xtal;
   always @(posedge clk) if (vld) chk(nq.pop_front(), seen, eq.pop_front());
   initial begin
      #500000;
      errors++;
      complete_run();
   end
   // ********
   // Tasks
   // ********
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   task automatic chk(string s, logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", s, exp, got);
      end
   endtask : chk
   task automatic see(string s, logic [31:0] v, logic [31:0] x);
      nq.push_back(s);
      eq.push_back(x);
      seen <= v;
      vld <= 1;
      @(posedge clk);
      vld <= 0;
      @(posedge clk);
   endtask : see
   task automatic ahb(logic w, logic [7:0] ad, logic [31:0] wd);
      htrans <= 2'b10;
      haddr <= {24'h0, ad};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : ahb
   task automatic frame(logic [31:0] c);
      ahb(1, HOST_CTRL_OFS, c);
      do ahb(0, HOST_STATUS_OFS, 0); while (r[STAT_DONE_BIT] !== 1'b1);
      ahb(0, HOST_RDATA_OFS, 0);
   endtask : frame
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      repeat (3) @(posedge clk);
      rst_h <= 1;
      rst_d <= 1;
      repeat (4) @(posedge clk);
      ahb(0, 8'h40, 0);
      see("unmapped", r, 0);
      see("hresp", hresp, 0);
      see("pin_en_low", seoe, 0);
      // Source and kind codes both i, last pass crystal by source code 11
      for (int i = 0; i < 5; i++) begin
         ahb(1, HOST_PINS_OFS, (i == 4) ? 32'h26 : 32'h20 | i * 32'h0a);
         repeat (8) @(posedge clk);
         if (i == 4) see("enable", ooe, 1);
         repeat (60) @(posedge clk);
         see("kind", okind, i % 4);
         see("oe", ooe, i != 3);
         if (i == 0) see("pin_en_high", seoe, 1);
         if (i != 3) begin
            see("comp", ocomp, !otrue);
            n = 0;
            repeat (200) begin
               @(posedge clk);
               n += otrue && !p;
               p = otrue;
            end
            e = (i > 1) ? 5 : (i == 1) ? 9 : 20;
            see("track", n >= e - 1 && n <= e + 1, 1);
         end
      end
      ahb(1, HOST_PINS_OFS, 32'h21);
      rst_d <= 0;
      repeat (3) @(posedge clk);
      rst_d <= 1;
      do @(posedge clk); while (mready !== 1'b1);
      see("serial", smode, 1);
      for (int i = 0; i < 5; i++) begin
         a = (i == 4) ? 7'h1c : 7'(xs() % 28);
         d = xs();
         ahb(1, HOST_WDATA_OFS, d);
         frame(32'(a) << CTRL_ADDR_LSB | 32'h31 | (i[0] ? 32'h4 : 32'h0));
         if (i < 4) frame(32'(a) << CTRL_ADDR_LSB | 32'h33 | (i[0] ? 32'h0 : 32'h4));
         else frame(32'h1e23);
         see("rdata", r, (i < 4) ? d : d >> 16);
      end
      for (int j = 0; j < 2; j++) begin
         ahb(1, HOST_WDATA_OFS, j ? 32'h10 : 32'h30);
         frame(32'(REG_KIND_IDX) << CTRL_ADDR_LSB | 32'h01);
         repeat (60) @(posedge clk);
         see("skind", okind, j ? KIND_LVDS : KIND_OFF);
         see("soe", ooe, j);
      end
      ahb(1, HOST_PINS_OFS, 32'h00);
      repeat (10) @(posedge clk);
      see("mode", smode, 1);
      see("serial_en", seoe, 1);
      complete_run();
   end
endmodule : tb_top
